// file: verilog/ems_pkg.sv
// types and constants of the extended-mode bus cycle sequencer
// assumes one bus cycle per clk_sys period and a bus synchronous to clk_sys
package ems_pkg;

	// ----------------------------------------------------------------
	// instruction groups
	// ----------------------------------------------------------------
	typedef enum logic [11:0] {
		GRP_JUMP    = 12'h001,
		GRP_READ8   = 12'h002,
		GRP_STORE8  = 12'h004,
		GRP_LOAD16  = 12'h008,
		GRP_STORE16 = 12'h010,
		GRP_LOAD_Y  = 12'h020,
		GRP_STORE_Y = 12'h040,
		GRP_RMW     = 12'h080,
		GRP_TEST    = 12'h100,
		GRP_ARITH16 = 12'h200,
		GRP_CMP_Y   = 12'h400,
		GRP_CALL    = 12'h800
	} ems_grp_type;

	// ----------------------------------------------------------------
	// bus cycle kinds, one state per cycle
	// ----------------------------------------------------------------
	typedef enum logic [12:0] {
		ST_IDLE      = 13'h0001,
		ST_PREFIX    = 13'h0002,
		ST_OPCODE    = 13'h0004,
		ST_ADDR_HI   = 13'h0008,
		ST_ADDR_LO   = 13'h0010,
		ST_DATA_HI   = 13'h0020,
		ST_DATA_LO   = 13'h0040,
		ST_DUMMY     = 13'h0080,
		ST_DUMMY2    = 13'h0100,
		ST_RESULT    = 13'h0200,
		ST_SUB_FETCH = 13'h0400,
		ST_PUSH_LO   = 13'h0800,
		ST_PUSH_HI   = 13'h1000
	} ems_st_type;

	// ----------------------------------------------------------------
	// constants
	// ----------------------------------------------------------------
	localparam logic [15:0] DUMMY_ADDR = 16'hFFFF;
	localparam logic [15:0] RET_OFFSET = 16'h0003;
	localparam logic [15:0] ADDR_STEP  = 16'h0001;
	localparam logic [15:0] WORD_RST   = 16'h0000;
	localparam logic [7:0]  BYTE_RST   = 8'h00;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		ems_grp_type grp;
		logic [15:0] opc_addr;
		logic [15:0] stack_ptr;
		logic [15:0] reg_data;
	} ems_req_type;

	typedef struct packed {
		logic        active;
		logic        rw;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} ems_bus_type;

	typedef struct packed {
		ems_st_type  st;
		ems_grp_type grp;
		logic [15:0] fptr;
		logic [15:0] ea;
		logic [15:0] sp;
		logic [15:0] ret;
		logic [15:0] wdat;
		logic [7:0]  rmw_byte;
		logic [15:0] rd_word;
		logic        busy;
		logic        done;
		ems_bus_type bus;
	} ems_state_type;

	localparam ems_bus_type BUS_RST = '{
		active: 1'b0,
		rw:     1'b1,
		addr:   WORD_RST,
		wdata:  BYTE_RST
	};

	localparam ems_state_type STATE_RST = '{
		st:       ST_IDLE,
		grp:      GRP_JUMP,
		fptr:     WORD_RST,
		ea:       WORD_RST,
		sp:       WORD_RST,
		ret:      WORD_RST,
		wdat:     WORD_RST,
		rmw_byte: BYTE_RST,
		rd_word:  WORD_RST,
		busy:     1'b0,
		done:     1'b0,
		bus:      BUS_RST
	};

endpackage

// file: verilog/ems_sequencer.sv
// extended-mode bus cycle sequencer: one bus cycle per clock, per-group cycle tables
// assumes bus_rdata and rmw_result are synchronous to clk_sys and valid at the
// edge that ends the cycle in which they are read
module ems_sequencer (
	input  wire logic                 clk_sys,    // system clock
	input  wire logic                 rst_n,      // async reset, active low
	input  wire logic                 req_valid,  // start pulse, taken when idle
	input  wire ems_pkg::ems_req_type req,        // group, opcode address, sp, register data
	input  wire logic [7:0]           bus_rdata,  // read data of current cycle
	input  wire logic [7:0]           rmw_result, // modified operand from the alu
	output logic                      busy,       // sequence in progress
	output logic                      done,       // one-cycle pulse after last cycle
	output logic [15:0]               rd_word,    // bytes read, last byte lowest
	output logic [15:0]               oper_addr,  // operand or jump target address
	output ems_pkg::ems_bus_type      bus         // address, rw, write data, active
);

	// ----------------------------------------------------------------
	// decoding helpers
	// ----------------------------------------------------------------
	// groups that open with the page-select byte and so fetch one byte more
	function automatic logic is_prefixed(input ems_pkg::ems_grp_type g);
		case (g)
			ems_pkg::GRP_LOAD_Y,
			ems_pkg::GRP_STORE_Y,
			ems_pkg::GRP_CMP_Y: begin
				is_prefixed = 1'b1;
			end
			default: begin
				is_prefixed = 1'b0;
			end
		endcase
	endfunction

	// groups whose data cycles drive the register bytes out
	function automatic logic is_store(input ems_pkg::ems_grp_type g);
		case (g)
			ems_pkg::GRP_STORE8,
			ems_pkg::GRP_STORE16,
			ems_pkg::GRP_STORE_Y: begin
				is_store = 1'b1;
			end
			default: begin
				is_store = 1'b0;
			end
		endcase
	endfunction

	// byte read and byte store groups: the single data cycle is the last one
	function automatic logic ends_at_data_hi(input ems_pkg::ems_grp_type g);
		case (g)
			ems_pkg::GRP_READ8,
			ems_pkg::GRP_STORE8: begin
				ends_at_data_hi = 1'b1;
			end
			default: begin
				ends_at_data_hi = 1'b0;
			end
		endcase
	endfunction

	// byte-wide groups that idle the bus at all-ones after the operand read
	function automatic logic dummy_after_hi(input ems_pkg::ems_grp_type g);
		case (g)
			ems_pkg::GRP_RMW,
			ems_pkg::GRP_TEST: begin
				dummy_after_hi = 1'b1;
			end
			default: begin
				dummy_after_hi = 1'b0;
			end
		endcase
	endfunction

	// word groups that spend one more cycle at all-ones for the 16-bit alu pass
	function automatic logic dummy_after_lo(input ems_pkg::ems_grp_type g);
		case (g)
			ems_pkg::GRP_ARITH16,
			ems_pkg::GRP_CMP_Y: begin
				dummy_after_lo = 1'b1;
			end
			default: begin
				dummy_after_lo = 1'b0;
			end
		endcase
	endfunction

	function automatic ems_pkg::ems_st_type next_state(
		input ems_pkg::ems_grp_type g,
		input ems_pkg::ems_st_type  s
	);
		next_state = ems_pkg::ST_IDLE;
		unique case (s)
			ems_pkg::ST_PREFIX: begin
				next_state = ems_pkg::ST_OPCODE;
			end
			ems_pkg::ST_OPCODE: begin
				next_state = ems_pkg::ST_ADDR_HI;
			end
			ems_pkg::ST_ADDR_HI: begin
				next_state = ems_pkg::ST_ADDR_LO;
			end
			ems_pkg::ST_ADDR_LO: begin
				if (g == ems_pkg::GRP_JUMP) begin
					next_state = ems_pkg::ST_IDLE;
				end else if (g == ems_pkg::GRP_CALL) begin
					next_state = ems_pkg::ST_SUB_FETCH;
				end else begin
					next_state = ems_pkg::ST_DATA_HI;
				end
			end
			ems_pkg::ST_DATA_HI: begin
				if (ends_at_data_hi(g)) begin
					next_state = ems_pkg::ST_IDLE;
				end else if (dummy_after_hi(g)) begin
					next_state = ems_pkg::ST_DUMMY;
				end else begin
					next_state = ems_pkg::ST_DATA_LO;
				end
			end
			ems_pkg::ST_DATA_LO: begin
				if (dummy_after_lo(g)) begin
					next_state = ems_pkg::ST_DUMMY;
				end else begin
					next_state = ems_pkg::ST_IDLE;
				end
			end
			ems_pkg::ST_DUMMY: begin
				if (g == ems_pkg::GRP_RMW) begin
					next_state = ems_pkg::ST_RESULT;
				end else if (g == ems_pkg::GRP_TEST) begin
					next_state = ems_pkg::ST_DUMMY2;
				end else begin
					next_state = ems_pkg::ST_IDLE;
				end
			end
			ems_pkg::ST_SUB_FETCH: begin
				next_state = ems_pkg::ST_PUSH_LO;
			end
			ems_pkg::ST_PUSH_LO: begin
				next_state = ems_pkg::ST_PUSH_HI;
			end
			default: begin
				// idle, last cycles and illegal codes all fall back to idle
				next_state = ems_pkg::ST_IDLE;
			end
		endcase
	endfunction

	// bus drive for the cycle that a state stands for
	function automatic ems_pkg::ems_bus_type bus_of(input ems_pkg::ems_state_type c);
		bus_of        = ems_pkg::BUS_RST;
		bus_of.active = c.st != ems_pkg::ST_IDLE;
		unique case (c.st)
			ems_pkg::ST_PREFIX,
			ems_pkg::ST_OPCODE,
			ems_pkg::ST_ADDR_HI,
			ems_pkg::ST_ADDR_LO: begin
				bus_of.addr = c.fptr;
			end
			ems_pkg::ST_DATA_HI: begin
				bus_of.addr = c.ea;
				if (is_store(c.grp)) begin
					bus_of.rw = 1'b0;
					// a byte store has only one data cycle, so it carries the low byte
					if (c.grp == ems_pkg::GRP_STORE8) begin
						bus_of.wdata = c.wdat[7:0];
					end else begin
						bus_of.wdata = c.wdat[15:8];
					end
				end
			end
			ems_pkg::ST_DATA_LO: begin
				bus_of.addr = c.ea + ems_pkg::ADDR_STEP;
				if (is_store(c.grp)) begin
					bus_of.rw = 1'b0;
					bus_of.wdata = c.wdat[7:0];
				end
			end
			ems_pkg::ST_DUMMY,
			ems_pkg::ST_DUMMY2: begin
				bus_of.addr = ems_pkg::DUMMY_ADDR;
			end
			ems_pkg::ST_RESULT: begin
				bus_of.addr  = c.ea;
				bus_of.rw    = 1'b0;
				bus_of.wdata = c.rmw_byte;
			end
			ems_pkg::ST_SUB_FETCH: begin
				bus_of.addr = c.ea;
			end
			ems_pkg::ST_PUSH_LO: begin
				bus_of.addr  = c.sp;
				bus_of.rw    = 1'b0;
				bus_of.wdata = c.ret[7:0];
			end
			ems_pkg::ST_PUSH_HI: begin
				bus_of.addr  = c.sp - ems_pkg::ADDR_STEP;
				bus_of.rw    = 1'b0;
				bus_of.wdata = c.ret[15:8];
			end
			default: begin
				// idle: bus released, line held high
				bus_of = ems_pkg::BUS_RST;
			end
		endcase
	endfunction

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	ems_pkg::ems_state_type q_ff;
	ems_pkg::ems_state_type nxt_q;

	always_comb begin
		nxt_q      = q_ff;
		nxt_q.done = 1'b0;
		// capture what the current cycle read
		unique case (q_ff.st)
			ems_pkg::ST_PREFIX,
			ems_pkg::ST_OPCODE: begin
				nxt_q.fptr = q_ff.fptr + ems_pkg::ADDR_STEP;
			end
			ems_pkg::ST_ADDR_HI: begin
				nxt_q.fptr      = q_ff.fptr + ems_pkg::ADDR_STEP;
				nxt_q.ea[15:8]  = bus_rdata;
			end
			ems_pkg::ST_ADDR_LO: begin
				nxt_q.fptr      = q_ff.fptr + ems_pkg::ADDR_STEP;
				nxt_q.ea[7:0]   = bus_rdata;
			end
			ems_pkg::ST_DATA_HI,
			ems_pkg::ST_DATA_LO,
			ems_pkg::ST_SUB_FETCH: begin
				if (q_ff.bus.rw) begin
					nxt_q.rd_word = {q_ff.rd_word[7:0], bus_rdata};
				end
			end
			ems_pkg::ST_DUMMY: begin
				// the alu has had the operand for a full cycle by now
				if (q_ff.grp == ems_pkg::GRP_RMW) begin
					nxt_q.rmw_byte = rmw_result;
				end
			end
			default: begin
				nxt_q.fptr = q_ff.fptr;
			end
		endcase
		// advance; a new request only from idle so sequences never overlap
		if (q_ff.st == ems_pkg::ST_IDLE) begin
			if (req_valid) begin
				nxt_q.grp     = req.grp;
				nxt_q.fptr    = req.opc_addr;
				nxt_q.sp      = req.stack_ptr;
				nxt_q.wdat    = req.reg_data;
				nxt_q.ret     = req.opc_addr + ems_pkg::RET_OFFSET;
				nxt_q.ea      = ems_pkg::WORD_RST;
				nxt_q.rd_word = ems_pkg::WORD_RST;
				nxt_q.st      = is_prefixed(req.grp) ? ems_pkg::ST_PREFIX
					: ems_pkg::ST_OPCODE;
			end
		end else begin
			nxt_q.st = next_state(q_ff.grp, q_ff.st);
			if (nxt_q.st == ems_pkg::ST_IDLE) begin
				nxt_q.done = 1'b1;
			end
		end
		nxt_q.busy = nxt_q.st != ems_pkg::ST_IDLE;
		nxt_q.bus  = bus_of(nxt_q);
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			q_ff <= ems_pkg::STATE_RST;
		end else begin
			q_ff <= nxt_q;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign busy      = q_ff.busy;
	assign done      = q_ff.done;
	assign rd_word   = q_ff.rd_word;
	assign oper_addr = q_ff.ea;
	assign bus       = q_ff.bus;

endmodule

// file: verification/ems_mem_model.sv
// memory side model: answers reads from a fixed address pattern, ignores writes
// assumes the sequencer samples bus_rdata at the edge that ends each cycle
module ems_mem_model (
	input  wire logic                 clk_sys,   // system clock
	input  wire ems_pkg::ems_bus_type bus,       // cycle from the sequencer
	output logic [7:0]                bus_rdata  // read data
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] last_ff;
	logic [7:0] pat;
	assign pat = bus.addr[7:0] ^ {bus.addr[3:0], bus.addr[15:12]} ^ 8'h3C;
	// released line shows the inverse of its last value, so stale data cannot pass
	assign bus_rdata = (bus.active && bus.rw) ? pat : ~last_ff;
	always @(posedge clk_sys) last_ff <= bus_rdata;
endmodule

// file: verification/ems_sequencer_assertions.sv
// cycle-table checks of the sequencer, watching only its ports
// assumes one bus cycle per clk_sys period and requests taken only while idle
module ems_seq_chk (
	input wire logic                 clk_sys,    // system clock
	input wire logic                 rst_n,      // async reset, active low
	input wire logic                 req_valid,  // start request
	input wire ems_pkg::ems_req_type req,        // request fields
	input wire logic [7:0]           bus_rdata,  // read data
	input wire logic [7:0]           rmw_result, // alu result
	input wire logic                 busy,       // sequence running
	input wire logic                 done,       // end pulse
	input wire logic [15:0]          rd_word,    // read bytes
	input wire logic [15:0]          oper_addr,  // operand address
	input wire ems_pkg::ems_bus_type bus         // bus cycle
);
	// ----
	// properties
	// ----
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);
	wire tk = !busy && req_valid;
	property p_jump;
		tk && req.grp == ems_pkg::GRP_JUMP |=> bus.active[*3] ##1 done;
	endproperty
	a_jump: assert property (p_jump) else $error("jump length wrong");
	property p_read8;
		tk && req.grp == ems_pkg::GRP_READ8 |=> bus.rw[*4] ##1 done;
	endproperty
	a_read8: assert property (p_read8) else $error("read group wrong");
	property p_store8;
		tk && req.grp == ems_pkg::GRP_STORE8 |=> bus.rw[*3]
			##1 (!bus.rw && bus.wdata == $past(req.reg_data[7:0], 4)) ##1 done;
	endproperty
	a_store8: assert property (p_store8) else $error("byte store wrong");
	property p_store16;
		tk && req.grp == ems_pkg::GRP_STORE16 |=> ##3
			(!bus.rw && bus.wdata == $past(req.reg_data[15:8], 4))
			##1 (!bus.rw && bus.addr == $past(bus.addr) + 16'h0001);
	endproperty
	a_store16: assert property (p_store16) else $error("word store wrong");
	property p_rmw;
		tk && req.grp == ems_pkg::GRP_RMW |=> ##4 (bus.rw && bus.addr == ems_pkg::DUMMY_ADDR)
			##1 (!bus.rw && bus.addr == $past(bus.addr, 2) && bus.wdata == $past(rmw_result));
	endproperty
	a_rmw: assert property (p_rmw) else $error("rmw tail wrong");
	property p_test;
		tk && req.grp == ems_pkg::GRP_TEST |=> bus.rw[*4]
			##1 (bus.rw && bus.addr == ems_pkg::DUMMY_ADDR)[*2] ##1 done;
	endproperty
	a_test: assert property (p_test) else $error("test sequence wrong");
	property p_cmp_y;
		tk && req.grp == ems_pkg::GRP_CMP_Y |=> bus.active[*7] ##1 (done && !bus.active);
	endproperty
	a_cmp_y: assert property (p_cmp_y) else $error("prefixed compare length wrong");
	property p_call;
		tk && req.grp == ems_pkg::GRP_CALL |=> ##4 (!bus.rw && bus.addr == $past(req.stack_ptr, 5))
			##1 (!bus.rw && bus.addr == $past(req.stack_ptr, 6) - 16'h0001);
	endproperty
	a_call: assert property (p_call) else $error("call push wrong");
	property p_idle_rw;
		!bus.active |-> bus.rw;
	endproperty
	a_idle_rw: assert property (p_idle_rw) else $error("write outside a cycle");
	c_rmw: cover property (tk && req.grp == ems_pkg::GRP_RMW);
	c_call: cover property (tk && req.grp == ems_pkg::GRP_CALL);
	c_b2b: cover property (done && req_valid);
endmodule
bind ems_sequencer ems_seq_chk u_chk (.clk_sys(clk_sys), .rst_n(rst_n), .req_valid(req_valid),
	.req(req), .bus_rdata(bus_rdata), .rmw_result(rmw_result), .busy(busy), .done(done),
	.rd_word(rd_word), .oper_addr(oper_addr), .bus(bus));

// file: verification/extended_mode_bus_cycle_sequencer_tb.sv
// self-checking bench: queue model of every group's cycle table against the sequencer
// assumes the memory model's fixed read pattern and a 10 MHz clk_sys
module extended_mode_bus_cycle_sequencer_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic                 clk_sys    = 1'b0;
	logic                 rst_n      = 1'b0;
	logic                 req_valid  = 1'b0;
	ems_pkg::ems_req_type req        = '0;
	logic [7:0]           rmw_result = 8'h00;
	logic [7:0]           bus_rdata, nrmw;
	logic                 busy, done;
	logic [15:0]          rd_word, oper_addr;
	ems_pkg::ems_bus_type bus;
	ems_pkg::ems_req_type nr;
	logic [15:0]          qa[$];
	int                   qr[$], qd[$];
	int                   n_fail = 0, samples_checked = 0, ng, gi;
	always #50 clk_sys = ~clk_sys;
	ems_sequencer u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .req_valid(req_valid), .req(req),
		.bus_rdata(bus_rdata), .rmw_result(rmw_result), .busy(busy), .done(done),
		.rd_word(rd_word), .oper_addr(oper_addr), .bus(bus));
	ems_mem_model u_mem (.clk_sys(clk_sys), .bus(bus), .bus_rdata(bus_rdata));
	// ----
	// helpers
	// ----
	function automatic logic [7:0] mf(input logic [15:0] a);
		return a[7:0] ^ {a[3:0], a[15:12]} ^ 8'h3C;
	endfunction
	task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic push(input logic [15:0] a, input int r, input int d);
		qa.push_back(a);
		qr.push_back(r);
		qd.push_back(d);
	endtask
	task automatic pick(input int g);
		ng = g;
		nr = '{grp: ems_pkg::ems_grp_type'(12'h001 << g), opc_addr: 16'($urandom),
			stack_ptr: 16'($urandom), reg_data: 16'($urandom)};
		nrmw = 8'($urandom);
	endtask
	// refused requests: with keep set, req_valid stays high through the busy cycles
	task automatic run(input bit keep, input int g_next);
		logic [15:0] pc, hi, ea, ret, erd;
		int nf, d, g;
		g = ng;
		pc = nr.opc_addr;
		ret = pc + 16'h0003;
		nf = (g inside {5, 6, 10}) ? 4 : 3;
		hi = pc + 16'(nf - 2);
		ea = {mf(hi), mf(hi + 16'h0001)};
		erd = (g inside {3, 5}) ? {mf(ea), mf(ea + 16'h0001)} : {8'h00, mf(ea)};
		for (int i = 0; i < nf; i++) begin
			push(pc + 16'(i), 1, -1);
		end
		case (g)
			1, 3, 5, 7, 8, 9, 10, 11: push(ea, 1, -1);
			2: push(ea, 0, nr.reg_data[7:0]);
			4, 6: push(ea, 0, nr.reg_data[15:8]);
			default: ;
		endcase
		case (g)
			3, 5, 9, 10: push(ea + 16'h0001, 1, -1);
			4, 6: push(ea + 16'h0001, 0, nr.reg_data[7:0]);
			7, 8: push(16'hFFFF, 1, -1);
			11: push(nr.stack_ptr, 0, ret[7:0]);
			default: ;
		endcase
		case (g)
			7: push(ea, 0, nrmw);
			8, 9, 10: push(16'hFFFF, 1, -1);
			11: push(nr.stack_ptr - 16'h0001, 0, ret[15:8]);
			default: ;
		endcase
		if (req_valid !== 1'b1) begin
			@(posedge clk_sys);
			req_valid <= 1'b1;
			req <= nr;
			rmw_result <= nrmw;
		end
		@(posedge clk_sys);
		req_valid <= keep;
		while (qa.size() > 0) begin
			@(negedge clk_sys);
			d = qd.pop_front();
			chk("active", bus.active, 1'b1);
			chk("addr", bus.addr, qa.pop_front());
			chk("rw", bus.rw, qr.pop_front());
			if (d >= 0) chk("wdata", bus.wdata, d);
		end
		@(posedge clk_sys);
		pick(g_next);
		if (keep) begin
			req <= nr;
			rmw_result <= nrmw;
		end
		@(negedge clk_sys);
		chk("done", {done, bus.active, bus.rw}, 3'b101);
		chk("oper_addr", oper_addr, ea);
		if (g inside {1, 3, 5, 11}) chk("rd_word", rd_word, erd);
	endtask
	// ----
	// sequence
	// ----
	initial begin
		repeat (30000) @(posedge clk_sys);
		n_fail++;
		stop_test();
	end
	initial begin
		void'($urandom(71610));
		pick(0);
		repeat (8) @(posedge clk_sys);
		rst_n <= 1'b1;
		@(negedge clk_sys);
		chk("reset bus", bus, ems_pkg::BUS_RST);
		for (gi = 1; gi < 80; gi++) begin
			run(1'($urandom), gi < 12 ? gi : int'($urandom % 12));
		end
		@(posedge clk_sys);
		req_valid <= 1'b1;
		req <= nr;
		repeat (2) @(posedge clk_sys);
		rst_n <= 1'b0;
		req_valid <= 1'b0;
		@(negedge clk_sys);
		chk("mid reset", {busy, done, rd_word, oper_addr, bus}, {34'h0, ems_pkg::BUS_RST});
		@(posedge clk_sys);
		rst_n <= 1'b1;
		run(1'b0, 0);
		stop_test();
	end
endmodule
